// file: dv/gpio_board_model.sv
/*
  Board side of the six multiplexed pins: pull-ups plus a driver per line.
  Assumes the bench sets ext_en/ext_val off the clock edge.
*/
`timescale 1ns/1ps
module gpio_board_model (
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] ext_en,
  input  wire logic [5:0] ext_val,
  output logic      [5:0] pin_in
);
  // device drive wins; a released, undriven line floats up to the pull-up
  always_comb begin
    for (int i = 0; i < 6; i++) pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
  end
endmodule

// file: dv/gpio_pin_config_bank_props.sv
/*
  Port-level checker for the pin configuration bank.
  Assumes zero-wait APB and pads that follow a config write one edge later.
*/
`timescale 1ns/1ps
module gpio_cfg_checker (
  input wire logic                              pclk,
  input wire logic                              presetn,
  input wire logic                              hard_reset,
  input wire logic [gpio_cfg_pkg::ADDR_W-1:0]   paddr,
  input wire logic                              psel,
  input wire logic                              penable,
  input wire logic                              pwrite,
  input wire logic [gpio_cfg_pkg::DATA_W-1:0]   pwdata,
  input wire logic [3:0]                        pstrb,
  input wire logic [gpio_cfg_pkg::DATA_W-1:0]   prdata,
  input wire logic                              pready,
  input wire logic                              pslverr,
  input wire logic                              device_disable_lock_ctl,
  input wire logic                              device_disable_ro,
  input wire logic                              edge_irq2,
  input wire logic                              edge_irq3,
  input wire logic [gpio_cfg_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [gpio_cfg_pkg::NUM_PINS-1:0] pin_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic rd;
  // qualified access-phase strobes
  assign wr = psel && penable && pwrite && pstrb[0];
  assign rd = psel && penable && !pwrite;

  dir_input_a: assert property (
    wr && paddr == 12'h0e4 && pwdata[0] |-> ##2 !pin_oe[0]) else $error("pin 3.6 driven after input select");
  od_low_only_a: assert property (
    wr && paddr == 12'h0e4 && pwdata[7] |-> ##2 !pin_out[0]) else $error("open drain pin driven high");
  rsv_one_a: assert property (
    rd && paddr == 12'h0e4 |-> prdata[31:8] == 24'h0 && prdata[6:3] == 4'h0) else $error("reserved bits set");
  rsv_two_a: assert property (
    rd && paddr == 12'h0f0 |-> prdata[31:8] == 24'h0 && prdata[6:4] == 3'h0) else $error("reserved bits set");
  lock_hold_a: assert property (
    device_disable_lock_ctl && !hard_reset |=> device_disable_lock_ctl) else $error("lock dropped without reset");
  ro_needs_lock_a: assert property (
    device_disable_ro |-> $past(device_disable_lock_ctl)) else $error("read-only without lock");
  err_phase_a: assert property (
    pslverr |-> psel && penable) else $error("error outside access phase");
  ready_access_a: assert property (
    psel && penable |-> pready) else $error("access phase not ready");
  unaligned_err_a: assert property (
    psel && penable && paddr[1:0] != 2'h0 |-> pslverr) else $error("unaligned access not refused");

  cover property (device_disable_ro);
  cover property (edge_irq2);
  cover property (edge_irq3);
  cover property (pslverr);
endmodule

bind gpio_pin_config_bank gpio_cfg_checker u_chk (
  .pclk(pclk), .presetn(presetn), .hard_reset(hard_reset), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .device_disable_lock_ctl(device_disable_lock_ctl),
  .device_disable_ro(device_disable_ro), .edge_irq2(edge_irq2), .edge_irq3(edge_irq3),
  .pin_out(pin_out), .pin_oe(pin_oe));

// file: dv/gpio_pin_config_bank_test.sv
/*
  Self-checking bench for the pin configuration bank, one task per scenario.
  Assumes the board model on the pins and an APB master in this module.
*/
`timescale 1ns/1ps
module gpio_pin_config_bank_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        hard_reset = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  fn_src = 4'h0;
  logic        pwr_req = 1'b0;
  logic        irq2, irq3, floppy, lock_ctl, dis_ro;
  logic [5:0]  pin_in, pin_out, pin_oe;
  logic [5:0]  ext_val = 6'h3f;
  logic [5:0]  ext_en  = 6'h3f;
  logic [31:0] sq;
  logic        se;
  int          err_total = 0;
  int          samples_checked = 0;

  always #5 pclk = ~pclk;

  gpio_pin_config_bank u_dut (
    .pclk(pclk), .presetn(presetn), .hard_reset(hard_reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .keyboard_reset_out(fn_src[0]), .gate_a20_out(fn_src[1]),
    .drive_density_sel0(fn_src[2]), .drive_density_sel1(fn_src[3]), .power_event_req(pwr_req),
    .edge_irq2(irq2), .edge_irq3(irq3), .floppy_on_parallel(floppy),
    .device_disable_lock_ctl(lock_ctl), .device_disable_ro(dis_ro),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

  gpio_board_model u_board (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, sq, se);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0, sq, se);
    chk("prdata", sq, exp);
  endtask

  // pads settle one edge after the write; wait a little more
  task automatic pad(input int i, input logic oe, input logic o);
    repeat (3) @(posedge pclk);
    chk("pin_oe", 32'(pin_oe[i]), 32'(oe));
    chk("pin_out", 32'(pin_out[i]), 32'(o));
  endtask

  task automatic toggle_count(input int j, output int n);
    n = 0;
    @(posedge pclk);
    ext_val[j] <= ~ext_val[j];
    repeat (8) begin
      @(posedge pclk);
      n += (j == 3) ? int'(irq2 === 1'b1) : int'(irq3 === 1'b1);
    end
  endtask

  task automatic t_reset;
    for (int i = 0; i < 6; i++) rd_chk(12'h0e4 + 12'(4 * i), 32'h01);
    chk("pin_oe", 32'(pin_oe), 32'h0);
    $display("test reset done");
  endtask

  // reserved bits drop; two-bit field only on 4.1 and 4.3
  task automatic t_rsv;
    for (int i = 0; i < 6; i++) begin
      wr(12'h0e4 + 12'(4 * i), 32'hffff_ffff);
      rd_chk(12'h0e4 + 12'(4 * i), (i == 3 || i == 5) ? 32'h8f : 32'h87);
      wr(12'h0e4 + 12'(4 * i), 32'h01);
    end
    $display("test reserved done");
  endtask

  task automatic t_err;
    apb(12'h004, 1'b0, 32'h0, sq, se);
    chk("pslverr", 32'(se), 32'h1);
    chk("prdata", sq, 32'h0);
    apb(12'h0e5, 1'b1, 32'h80, sq, se);
    chk("pslverr", 32'(se), 32'h1);
    rd_chk(12'h0e4, 32'h01);
    $display("test refused done");
  endtask

  task automatic t_gpio;
    wr(12'h120, 32'h01);
    wr(12'h0e4, 32'h00);
    pad(0, 1'b1, 1'b1);
    wr(12'h0e4, 32'h02);
    pad(0, 1'b1, 1'b0);
    wr(12'h0e4, 32'h80);
    pad(0, 1'b0, 1'b0);
    wr(12'h120, 32'h00);
    pad(0, 1'b1, 1'b0);
    ext_en[0] <= 1'b0; // board lets go: only the pull-up holds the line
    ext_val[0] <= 1'b0;
    wr(12'h0e4, 32'h03);
    pad(0, 1'b0, 1'b0);
    apb(12'h124, 1'b0, 32'h0, sq, se);
    chk("pin_state", sq, 32'h3e);
    ext_en[0] <= 1'b1;
    ext_val[0] <= 1'b1;
    wr(12'h0e4, 32'h01);
    $display("test gpio done");
  endtask

  // each source alone high, so a crossed route shows
  task automatic t_alt;
    for (int i = 0; i < 4; i++) begin
      fn_src <= 4'(1 << i);
      wr(12'h0e4 + 12'(4 * i), 32'h04);
      pad(i, 1'b1, 1'b1);
      fn_src <= 4'h0;
      pad(i, 1'b1, 1'b0);
      wr(12'h0e4 + 12'(4 * i), 32'h06);
      pad(i, 1'b1, 1'b1);
      wr(12'h0e4 + 12'(4 * i), 32'h01);
    end
    $display("test alternate done");
  endtask

  task automatic t_pme;
    pwr_req <= 1'b1;
    wr(12'h0f4, 32'h04);
    pad(4, 1'b1, 1'b0);
    pwr_req <= 1'b0;
    pad(4, 1'b1, 1'b1);
    wr(12'h0f4, 32'h84);
    pad(4, 1'b0, 1'b0);
    pwr_req <= 1'b1;
    pad(4, 1'b1, 1'b0);
    pwr_req <= 1'b0;
    wr(12'h0f4, 32'h01);
    $display("test power event done");
  endtask

  task automatic t_edge;
    int n;
    wr(12'h0f0, 32'h09);
    toggle_count(3, n);
    chk("edge_irq2 count", 32'(n), 32'h1);
    wr(12'h0f0, 32'h0d);
    toggle_count(3, n);
    chk("edge_irq2 count", 32'(n), 32'h0);
    wr(12'h0f8, 32'h0d);
    toggle_count(5, n);
    chk("edge_irq3 count", 32'(n), 32'h1);
    wr(12'h0f8, 32'h09);
    ext_val[5] <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("floppy_on_parallel", 32'(floppy), 32'h1);
    wr(12'h0f8, 32'h0b);
    repeat (4) @(posedge pclk);
    chk("floppy_on_parallel", 32'(floppy), 32'h0);
    wr(12'h0f0, 32'h01);
    $display("test edges done");
  endtask

  task automatic t_lock;
    wr(12'h0f8, 32'h05);
    @(posedge pclk); // flag is decoded straight from the field, so it is already set at the write edge
    chk("lock_ctl", 32'(lock_ctl), 32'h1);
    wr(12'h0f8, 32'h0c);
    rd_chk(12'h0f8, 32'h04);
    pad(5, 1'b0, 1'b0);
    chk("disable_ro", 32'(dis_ro), 32'h1);
    ext_val[5] <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("disable_ro", 32'(dis_ro), 32'h0);
    hard_reset <= 1'b1;
    @(posedge pclk);
    hard_reset <= 1'b0;
    rd_chk(12'h0f8, 32'h00);
    // a power-on reset in mid-run must free the locked field as well
    wr(12'h0f8, 32'h05);
    @(posedge pclk);
    chk("lock_ctl", 32'(lock_ctl), 32'h1);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(12'h0f8, 32'h01);
    chk("lock_ctl", 32'(lock_ctl), 32'h0);
    $display("test lock done");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog: the whole run needs well under this span
  initial begin
    repeat (6000) @(posedge pclk);
    err_total++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rsv();
    t_err();
    t_gpio();
    t_alt();
    t_pme();
    t_edge();
    t_lock();
    tally_and_finish();
  end
endmodule

// file: hw/gpio_cfg_pkg.sv
/*
  Constants shared by the pin configuration bank: register indexes,
  field positions, write masks, reset values and function codes.
  Assumes an APB slave with 32-bit data, one register per aligned word.
*/
package gpio_cfg_pkg;

  // geometry
  localparam int unsigned NUM_PINS   = 6;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned CFG_W      = 8;

  // register indexes as printed; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_PIN_3_6  = 12'h039;
  localparam logic [ADDR_W-1:0] IDX_PIN_3_7  = 12'h03a;
  localparam logic [ADDR_W-1:0] IDX_PIN_4_0  = 12'h03b;
  localparam logic [ADDR_W-1:0] IDX_PIN_4_1  = 12'h03c;
  localparam logic [ADDR_W-1:0] IDX_PIN_4_2  = 12'h03d;
  localparam logic [ADDR_W-1:0] IDX_PIN_4_3  = 12'h03e;
  localparam logic [ADDR_W-1:0] IDX_DATA_OUT = 12'h048;
  localparam logic [ADDR_W-1:0] IDX_PIN_STATE = 12'h049;
  localparam int unsigned       IDX_SHIFT    = 2;

  // pin slots inside the bank
  localparam int unsigned PIN_3_6 = 0;
  localparam int unsigned PIN_3_7 = 1;
  localparam int unsigned PIN_4_0 = 2;
  localparam int unsigned PIN_4_1 = 3;
  localparam int unsigned PIN_4_2 = 4;
  localparam int unsigned PIN_4_3 = 5;

  // field positions
  localparam int unsigned BIT_DIR    = 0;
  localparam int unsigned BIT_INV    = 1;
  localparam int unsigned BIT_ALT    = 2;
  localparam int unsigned FN_LO      = 2;
  localparam int unsigned FN_HI      = 3;
  localparam int unsigned BIT_OD     = 7;

  // writable bits: one-bit select registers and two-bit select registers
  localparam logic [CFG_W-1:0] MASK_ONE_BIT = 8'h87;
  localparam logic [CFG_W-1:0] MASK_TWO_BIT = 8'h8f;
  localparam logic [CFG_W-1:0] CFG_RESET    = 8'h01;
  localparam logic [NUM_PINS-1:0] DATA_RESET = 6'h00;

  // two-bit function codes
  typedef enum logic [1:0] {
    FN_GPIO      = 2'h0,
    FN_CODE_01   = 2'h1,
    FN_CODE_10   = 2'h2,
    FN_CODE_11   = 2'h3
  } fn_code_t;

endpackage

// file: hw/gpio_pad_cell.sv
/*
  One pad cell: applies direction, polarity and driver type to a pin.
  Assumes pin_level is already synchronised to pclk; pad outputs are
  registered so the board sees no combinational glitches.
*/
`timescale 1ns/1ps
module gpio_pad_cell (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic is_input,
  input  wire logic invert,
  input  wire logic open_drain,
  input  wire logic drive_value,
  input  wire logic pin_level,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      fn_level
);

  logic pin_out_reg;
  logic pin_out_next;
  logic pin_oe_reg;
  logic pin_oe_next;
  logic level;

  // polarity sits between the internal function and the pin
  always_comb begin
    level    = drive_value ^ invert;
    fn_level = pin_level ^ invert;
    if (is_input) begin
      pin_out_next = 1'b0;
      pin_oe_next  = 1'b0;
    end else if (open_drain) begin
      pin_out_next = 1'b0;                          // only ever pulls low
      pin_oe_next  = ~level;
    end else begin
      pin_out_next = level;
      pin_oe_next  = 1'b1;
    end
  end

  // pad drive registers, released at reset so the pin floats
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_reg <= 1'b0;
      pin_oe_reg  <= 1'b0;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg  <= pin_oe_next;
    end
  end

  assign pin_out = pin_out_reg;
  assign pin_oe  = pin_oe_reg;

endmodule

// file: hw/gpio_pin_config_bank.sv
/*
  Configuration bank for general purpose pins 3.6 to 4.3 with their
  alternate functions, reached over APB.
  Assumes presetn is the standby power-on reset, hard_reset is a pulse or
  level in the pclk domain, and the pins are asynchronous to pclk.
*/
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module gpio_pin_config_bank (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                hard_reset,
  // apb slave
  input  wire logic [gpio_cfg_pkg::ADDR_W-1:0]     paddr,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [gpio_cfg_pkg::DATA_W-1:0]     pwdata,
  input  wire logic [3:0]                          pstrb,
  output logic [gpio_cfg_pkg::DATA_W-1:0]          prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // internal function sources
  input  wire logic                                keyboard_reset_out,
  input  wire logic                                gate_a20_out,
  input  wire logic                                drive_density_sel0,
  input  wire logic                                drive_density_sel1,
  input  wire logic                                power_event_req,
  // internal function sinks
  output logic                                     edge_irq2,
  output logic                                     edge_irq3,
  output logic                                     floppy_on_parallel,
  output logic                                     device_disable_lock_ctl,
  output logic                                     device_disable_ro,
  // pins
  input  wire logic [gpio_cfg_pkg::NUM_PINS-1:0]   pin_in,
  output logic      [gpio_cfg_pkg::NUM_PINS-1:0]   pin_out,
  output logic      [gpio_cfg_pkg::NUM_PINS-1:0]   pin_oe
);

  localparam int unsigned NP = gpio_cfg_pkg::NUM_PINS;
  localparam int unsigned CW = gpio_cfg_pkg::CFG_W;
  localparam int unsigned DW = gpio_cfg_pkg::DATA_W;
  localparam int unsigned AW = gpio_cfg_pkg::ADDR_W;

  // register selector decoded from a byte address
  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_CFG,
    SEL_DATA_OUT,
    SEL_PIN_STATE
  } reg_sel_t;

  // decodes a byte address; slot is the pin for a config register
  function automatic reg_sel_t decode_sel(input logic [AW-1:0] addr);
    logic [AW-1:0] idx;
    idx = addr >> gpio_cfg_pkg::IDX_SHIFT;
    if (addr[gpio_cfg_pkg::IDX_SHIFT-1:0] != 2'h0) begin
      decode_sel = SEL_NONE;
    end else if (idx >= gpio_cfg_pkg::IDX_PIN_3_6 && idx <= gpio_cfg_pkg::IDX_PIN_4_3) begin
      decode_sel = SEL_CFG;
    end else if (idx == gpio_cfg_pkg::IDX_DATA_OUT) begin
      decode_sel = SEL_DATA_OUT;
    end else if (idx == gpio_cfg_pkg::IDX_PIN_STATE) begin
      decode_sel = SEL_PIN_STATE;
    end else begin
      decode_sel = SEL_NONE;
    end
  endfunction

  // slot means something only when decode_sel answers SEL_CFG
  function automatic logic [2:0] decode_slot(input logic [AW-1:0] addr);
    logic [AW-1:0] idx;
    idx = (addr >> gpio_cfg_pkg::IDX_SHIFT) - gpio_cfg_pkg::IDX_PIN_3_6;
    decode_slot = idx[2:0];
  endfunction

  // writable bits of one config register
  function automatic logic [CW-1:0] write_mask(input logic [2:0] slot);
    if (slot == 3'(gpio_cfg_pkg::PIN_4_1) || slot == 3'(gpio_cfg_pkg::PIN_4_3)) begin
      // pins 4.1 and 4.3 own the two-bit function field
      write_mask = gpio_cfg_pkg::MASK_TWO_BIT;
    end else begin
      write_mask = gpio_cfg_pkg::MASK_ONE_BIT;
    end
  endfunction

  // the two-bit function field of a config word
  function automatic logic [1:0] fn_field(input logic [CW-1:0] cfg);
    fn_field = cfg[gpio_cfg_pkg::FN_HI:gpio_cfg_pkg::FN_LO];
  endfunction

  // pin synchronisers: stage one feeds stage two only
  logic [NP-1:0] sync1_reg;
  logic [NP-1:0] sync1_next;
  logic [NP-1:0] sync2_reg;
  logic [NP-1:0] sync2_next;

  // no logic between the stages, so a metastable first stage stays contained
  always_comb begin
    sync1_next = pin_in;
    sync2_next = sync1_reg;
  end

  // both stages clear low, matching the edge history below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // configuration and data registers
  logic [CW-1:0] cfg_reg  [NP];
  logic [CW-1:0] cfg_next [NP];
  logic [NP-1:0] data_out_reg;
  logic [NP-1:0] data_out_next;
  logic [DW-1:0] prdata_reg;
  logic [DW-1:0] prdata_next;
  logic          err_reg;
  logic          err_next;
  logic [NP-1:0] fn_level;

  logic          setup_phase;
  logic          access_wr;
  reg_sel_t      sel;
  logic [2:0]    slot;
  logic [1:0]    fn_43;
  logic          lock_43;

  // bus phase and address decode
  assign setup_phase = psel & ~penable;
  assign access_wr   = psel & penable & pwrite & pstrb[0];
  assign sel         = decode_sel(paddr);
  assign slot        = decode_slot(paddr);
  assign fn_43       = fn_field(cfg_reg[gpio_cfg_pkg::PIN_4_3]);
  assign lock_43     = (fn_43 == gpio_cfg_pkg::FN_CODE_01);

  // register writes; only the low byte lane carries config data
  always_comb begin
    logic [CW-1:0] mask;
    logic [CW-1:0] wval;
    mask = '0;
    wval = '0;
    // every register holds unless written, except the pin 4.3 function field, which hard reset clears
    for (int i = 0; i < NP; i++) begin
      cfg_next[i] = cfg_reg[i];
    end
    data_out_next = data_out_reg;
    if (access_wr && sel == SEL_CFG) begin
      mask = write_mask(slot);
      wval = pwdata[CW-1:0] & mask;
      if (slot == 3'(gpio_cfg_pkg::PIN_4_3) && lock_43) begin
        // locked field keeps its code until reset
        wval[gpio_cfg_pkg::FN_HI:gpio_cfg_pkg::FN_LO] = gpio_cfg_pkg::FN_CODE_01;
      end
      cfg_next[slot] = wval;
    end else if (access_wr && sel == SEL_DATA_OUT) begin
      data_out_next = pwdata[NP-1:0];
    end
    // hard reset clears only the pin 4.3 function field, lock included
    if (hard_reset) begin
      cfg_next[gpio_cfg_pkg::PIN_4_3][gpio_cfg_pkg::FN_HI:gpio_cfg_pkg::FN_LO] = gpio_cfg_pkg::FN_GPIO;
    end
  end

  // standby power-on reset returns every pin to a plain input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NP; i++) begin
        cfg_reg[i] <= gpio_cfg_pkg::CFG_RESET;
      end
      data_out_reg <= gpio_cfg_pkg::DATA_RESET;
    end else begin
      for (int i = 0; i < NP; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
      data_out_reg <= data_out_next;
    end
  end

  // read data captured in setup so the access phase needs no wait state
  always_comb begin
    prdata_next = prdata_reg;
    err_next    = err_reg;
    if (setup_phase) begin
      // write setups load it too; nobody samples it then
      prdata_next = '0;
      err_next    = 1'b0;
      if (sel == SEL_CFG) begin
        prdata_next[CW-1:0] = cfg_reg[slot];
      end else if (sel == SEL_DATA_OUT) begin
        prdata_next[NP-1:0] = data_out_reg;
      end else if (sel == SEL_PIN_STATE) begin
        prdata_next[NP-1:0] = fn_level;
      end else begin
        err_next = 1'b1;
      end
    end
  end

  // read data and error held for the whole access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      err_reg    <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      err_reg    <= err_next;
    end
  end

  // zero wait states: the data was ready one cycle early
  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & err_reg;

  // effective pad controls and the value each pin drives
  logic [NP-1:0] eff_input;
  logic [NP-1:0] eff_invert;
  logic [NP-1:0] eff_od;
  logic [NP-1:0] drive_val;
  logic [1:0]    fn_41;

  // pin 4.1 function field, shared by the pad mux and the edge logic
  assign fn_41 = fn_field(cfg_reg[gpio_cfg_pkg::PIN_4_1]);

  always_comb begin
    // plain GPIO path first; a selected function then takes over its pin
    for (int i = 0; i < NP; i++) begin
      eff_input[i]  = cfg_reg[i][gpio_cfg_pkg::BIT_DIR];
      eff_invert[i] = cfg_reg[i][gpio_cfg_pkg::BIT_INV];
      eff_od[i]     = cfg_reg[i][gpio_cfg_pkg::BIT_OD];
      drive_val[i]  = data_out_reg[i];
    end
    if (cfg_reg[gpio_cfg_pkg::PIN_3_6][gpio_cfg_pkg::BIT_ALT]) begin
      drive_val[gpio_cfg_pkg::PIN_3_6] = keyboard_reset_out;
    end
    if (cfg_reg[gpio_cfg_pkg::PIN_3_7][gpio_cfg_pkg::BIT_ALT]) begin
      drive_val[gpio_cfg_pkg::PIN_3_7] = gate_a20_out;
    end
    if (cfg_reg[gpio_cfg_pkg::PIN_4_0][gpio_cfg_pkg::BIT_ALT]) begin
      drive_val[gpio_cfg_pkg::PIN_4_0] = drive_density_sel0;
    end
    if (fn_41 == gpio_cfg_pkg::FN_CODE_01) begin
      drive_val[gpio_cfg_pkg::PIN_4_1] = drive_density_sel1;
    end
    if (cfg_reg[gpio_cfg_pkg::PIN_4_2][gpio_cfg_pkg::BIT_ALT]) begin
      // request is active high inside; uninverted the pin idles high
      drive_val[gpio_cfg_pkg::PIN_4_2] = ~power_event_req;
    end
    if (lock_43) begin
      // device-disable control forces a plain non-inverted input
      eff_input[gpio_cfg_pkg::PIN_4_3]  = 1'b1;
      eff_invert[gpio_cfg_pkg::PIN_4_3] = 1'b0;
    end
  end

  // one pad cell per pin
  for (genvar g = 0; g < NP; g++) begin : g_pad
    gpio_pad_cell u_pad (
      .pclk        (pclk),
      .presetn     (presetn),
      .is_input    (eff_input[g]),
      .invert      (eff_invert[g]),
      .open_drain  (eff_od[g]),
      .drive_value (drive_val[g]),
      .pin_level   (sync2_reg[g]),
      .pin_out     (pin_out[g]),
      .pin_oe      (pin_oe[g]),
      .fn_level    (fn_level[g])
    );
  end

  // either-edge interrupt detection and input function outputs
  logic [NP-1:0] prev_reg;
  logic [NP-1:0] prev_next;
  logic          irq2_reg;
  logic          irq2_next;
  logic          irq3_reg;
  logic          irq3_next;
  logic          fpp_reg;
  logic          fpp_next;
  logic          ddro_reg;
  logic          ddro_next;
  logic [NP-1:0] toggled;

  // edges come from the synced pin before polarity: either-edge detection
  // does not care, and a polarity write then cannot fake an interrupt
  always_comb begin
    prev_next = sync2_reg;
    toggled   = sync2_reg ^ prev_reg;
    // pulses last one cycle and only while the function field selects them
    irq2_next = (fn_41 == gpio_cfg_pkg::FN_CODE_10) & toggled[gpio_cfg_pkg::PIN_4_1];
    irq3_next = (fn_43 == gpio_cfg_pkg::FN_CODE_11) & toggled[gpio_cfg_pkg::PIN_4_3];
    // the floppy feed is a level and does follow polarity
    fpp_next  = (fn_43 == gpio_cfg_pkg::FN_CODE_10) & fn_level[gpio_cfg_pkg::PIN_4_3];
    // high pin means the device-disable register is read-only
    ddro_next = lock_43 & sync2_reg[gpio_cfg_pkg::PIN_4_3];
  end

  // history resets low like the synchroniser, so no false edge after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= '0;
      irq2_reg <= 1'b0;
      irq3_reg <= 1'b0;
      fpp_reg  <= 1'b0;
      ddro_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      irq2_reg <= irq2_next;
      irq3_reg <= irq3_next;
      fpp_reg  <= fpp_next;
      ddro_reg <= ddro_next;
    end
  end

  // pulses and levels leave from registers; the lock flag from its field
  assign edge_irq2               = irq2_reg;
  assign edge_irq3               = irq3_reg;
  assign floppy_on_parallel      = fpp_reg;
  assign device_disable_lock_ctl = lock_43;
  assign device_disable_ro       = ddro_reg;

endmodule
